/* hw_standby_pkg.sv */
// Contract
// R1: standby pin low enters standby from anywhere
// R2: standby halts cpu, modules, floats ports
// R3: entering standby resets module registers
// R4: on-chip ram contents kept during standby
// R5: software clears ram enable before standby
// R6: boot selects stay unchanged during standby
// R7: both boot selects low gives programmer mode; the code raises it only in standby
// R8: exit needs standby release and reset release
// R9: standby release restarts oscillator, held reset
// R10: reset held low until clock settles
// R11: reset rising after release runs reset sequence
// R12: entry order: reset low, then standby low
// R13: exit order: standby high, settle, reset high
// R14: standby pin overrides reset pin
package hw_standby_pkg;

    // =========================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_RUN     = 3'b000,
        ST_STANDBY = 3'b001,
        ST_OSC_RUN = 3'b010,
        ST_RESET   = 3'b011
    } seq_state_e;

    // =========================================================
    // timing: reset sequence length after reset release, cycles
    localparam int unsigned RESET_SEQ_CYCLES = 16;
    localparam logic [4:0]  SEQ_CNT_RESET    = 5'h00;

endpackage

/* hw_standby_ctrl.sv */
`timescale 1ns/1ps
module hw_standby_ctrl #(
    parameter int unsigned SEQ_CYCLES = hw_standby_pkg::RESET_SEQ_CYCLES
) (
    // clock, reset, enable
    input  wire logic I_REF_CLK,
    input  wire logic I_SYS_RST,
    input  wire logic I_CLK_EN,
    // pins from the supervisor
    input  wire logic I_HW_SLEEP_REQUEST_N,
    input  wire logic I_CHIP_INIT_N,
    input  wire logic I_BOOT_SELECT_1,
    input  wire logic I_BOOT_SELECT_0,
    // controls into the chip
    output logic      O_CPU_HALT,
    output logic      O_MODULE_STOP,
    output logic      O_MODULE_RESET,
    output logic      O_PORT_HIZ,
    output logic      O_RAM_RETAIN,
    output logic      O_OSC_ENABLE,
    output logic      O_CPU_RESET,
    output logic      O_PROGRAMMER_MODE,
    output logic      O_IN_STANDBY
);

    // =========================================================
    // pin synchronisers; first stage read only by second stage
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic [3:0] next_sync_a;

    always_comb begin
        next_sync_a = {I_HW_SLEEP_REQUEST_N, I_CHIP_INIT_N,
                       I_BOOT_SELECT_1, I_BOOT_SELECT_0};
    end

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            sync_a <= 4'hF;
            sync_b <= 4'hF;
        end else if (I_CLK_EN) begin
            sync_a <= next_sync_a;
            sync_b <= sync_a;
        end
    end

    logic sleep_req_n;
    logic init_n;
    logic init_n_d;
    logic boot_both_low;
    assign sleep_req_n   = sync_b[3];
    assign init_n        = sync_b[2];
    assign boot_both_low = ~sync_b[1] & ~sync_b[0];

    // =========================================================
    // sequencer
    localparam int unsigned CW = 5;
    localparam logic [CW-1:0] SEQ_LAST = CW'(SEQ_CYCLES - 1);

    hw_standby_pkg::seq_state_e state;
    hw_standby_pkg::seq_state_e next_state;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_init_n_d;

    // next-state; standby pin checked first so it wins over reset
    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_init_n_d = init_n;
        if (!sleep_req_n) begin                          // R1 R14
            next_state = hw_standby_pkg::ST_STANDBY;
            next_cnt   = hw_standby_pkg::SEQ_CNT_RESET;
        end else begin
            case (state)
                hw_standby_pkg::ST_STANDBY: begin
                    // pin release alone never resumes execution
                    next_state = hw_standby_pkg::ST_OSC_RUN; // R8 R9
                end
                hw_standby_pkg::ST_OSC_RUN: begin
                    // wait for a true low-to-high on the reset pin
                    if (init_n && !init_n_d) begin       // R11
                        next_state = hw_standby_pkg::ST_RESET;
                        next_cnt   = hw_standby_pkg::SEQ_CNT_RESET;
                    end
                end
                hw_standby_pkg::ST_RESET: begin
                    if (cnt == SEQ_LAST) begin
                        next_state = hw_standby_pkg::ST_RUN;
                    end else begin
                        next_cnt = cnt + CW'(1);
                    end
                end
                default: begin
                    next_state = hw_standby_pkg::ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            state    <= hw_standby_pkg::ST_RUN;
            cnt      <= hw_standby_pkg::SEQ_CNT_RESET;
            init_n_d <= 1'b1;
        end else if (I_CLK_EN) begin
            state    <= next_state;
            cnt      <= next_cnt;
            init_n_d <= next_init_n_d;
        end
    end

    // =========================================================
    // registered outputs, decoded from the next state
    logic next_standby;
    logic next_held;
    always_comb begin
        next_standby = (next_state == hw_standby_pkg::ST_STANDBY);
        next_held    = next_standby
                     || (next_state == hw_standby_pkg::ST_OSC_RUN)
                     || (next_state == hw_standby_pkg::ST_RESET);
    end

    // ram is never cleared here; retain flag only gates its access
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_CPU_HALT        <= 1'b0;
            O_MODULE_STOP     <= 1'b0;
            O_MODULE_RESET    <= 1'b0;
            O_PORT_HIZ        <= 1'b0;
            O_RAM_RETAIN      <= 1'b0;
            O_OSC_ENABLE      <= 1'b1;
            O_CPU_RESET       <= 1'b0;
            O_PROGRAMMER_MODE <= 1'b0;
            O_IN_STANDBY      <= 1'b0;
        end else if (I_CLK_EN) begin
            O_CPU_HALT        <= next_standby;               // R2
            O_MODULE_STOP     <= next_standby;               // R2
            O_PORT_HIZ        <= next_standby;               // R2
            O_MODULE_RESET    <= next_held;                  // R3
            O_RAM_RETAIN      <= next_standby;               // R4
            O_OSC_ENABLE      <= ~next_standby;              // R9
            O_CPU_RESET       <= next_held;                  // R9 R11
            O_PROGRAMMER_MODE <= next_standby & boot_both_low; // R7
            O_IN_STANDBY      <= next_standby;
        end
    end

    // =========================================================
    // checks
    // pin low as seen on an enabled edge
    sequence s_pin_low;
        I_CLK_EN && !sleep_req_n;
    endsequence

    property p_enter;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST)
        s_pin_low |=> O_IN_STANDBY && O_CPU_HALT;
    endproperty
    a_enter: assert property (p_enter) else $error("no standby entry"); // R1

    property p_hiz;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST)
        O_IN_STANDBY |-> O_PORT_HIZ && O_MODULE_STOP && !O_OSC_ENABLE;
    endproperty
    a_hiz: assert property (p_hiz) else $error("standby outputs wrong"); // R2

    property p_modreset;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST)
        O_IN_STANDBY |-> O_MODULE_RESET && O_RAM_RETAIN;
    endproperty
    a_modreset: assert property (p_modreset) else $error("no reset"); // R3 R4

    property p_prog;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST)
        s_pin_low and boot_both_low |=> O_PROGRAMMER_MODE;
    endproperty
    a_prog: assert property (p_prog) else $error("no programmer mode"); // R7

    property p_release;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST)
        I_CLK_EN && state == hw_standby_pkg::ST_STANDBY && sleep_req_n
        |=> O_OSC_ENABLE && O_CPU_RESET;
    endproperty
    a_release: assert property (p_release) else $error("bad release"); // R8 R9

    property p_hold;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST)
        state == hw_standby_pkg::ST_OSC_RUN && !init_n
        |-> O_CPU_RESET;
    endproperty
    a_hold: assert property (p_hold) else $error("reset not held"); // R8

    property p_seq;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST)
        I_CLK_EN && state == hw_standby_pkg::ST_OSC_RUN && sleep_req_n
        && init_n && !init_n_d |=> state == hw_standby_pkg::ST_RESET;
    endproperty
    a_seq: assert property (p_seq) else $error("no reset sequence"); // R11

    property p_prio;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST)
        s_pin_low and init_n |=> O_IN_STANDBY && O_CPU_HALT;
    endproperty
    a_prio: assert property (p_prio) else $error("standby lost"); // R14

    // last count of the reset sequence hands back to program execution
    property p_seq_end;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST)
        I_CLK_EN && sleep_req_n && cnt == SEQ_LAST
        && state == hw_standby_pkg::ST_RESET
        |=> state == hw_standby_pkg::ST_RUN && !O_CPU_RESET
            && !O_MODULE_RESET;
    endproperty
    a_seq_end: assert property (p_seq_end) else $error("no run"); // R11

    // oscillator runs but the chip stays in reset
    property p_osc;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST)
        state == hw_standby_pkg::ST_OSC_RUN
        |-> O_OSC_ENABLE && O_CPU_RESET && !O_CPU_HALT && !O_PORT_HIZ;
    endproperty
    a_osc: assert property (p_osc) else $error("bad restart"); // R9

    // a low enable must not let the sequence count on
    property p_freeze;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST)
        !I_CLK_EN |=> $stable(state) && $stable(cnt) && $stable(O_CPU_RESET);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved"); // R11

endmodule

/* hw_supervisor_model.sv */
`timescale 1ns/1ps
module hw_supervisor_model (
    // clock and commands from the bench
    input  wire logic       i_clk,
    input  wire logic       i_sleep,
    input  wire logic [7:0] i_settle,
    input  wire logic [1:0] i_boot,
    // pins toward the device
    output logic            o_sleep_n,
    output logic            o_init_n,
    output logic [1:0]      o_boot,
    // software's ram enable bit, as the far side keeps it
    output logic            o_ram_enable
);
    logic [7:0] wait_cnt  = 8'h00;
    logic       sleep_n_q = 1'b1;
    logic       init_n_q  = 1'b1;
    logic [1:0] boot_q    = 2'h3;
    logic       ram_en_q  = 1'b1;

    // one driver per pin
    assign o_sleep_n    = sleep_n_q;
    assign o_init_n     = init_n_q;
    assign o_boot       = boot_q;
    assign o_ram_enable = ram_en_q;

    // =========================================================
    // pin sequencing, one step per edge so both orders are kept
    always @(posedge i_clk) begin
        if (i_sleep && init_n_q && sleep_n_q) begin
            init_n_q <= 1'b0;
            ram_en_q <= 1'b0;
        end else if (i_sleep && sleep_n_q) begin
            sleep_n_q <= 1'b0;
        end else if (!i_sleep && !sleep_n_q) begin
            sleep_n_q <= 1'b1;
            wait_cnt  <= i_settle;
        end else if (!i_sleep && !init_n_q) begin
            // settling is timed here, the device times only its reset sequence
            if (wait_cnt == 8'h00) begin
                init_n_q <= 1'b1;
            end else begin
                wait_cnt <= wait_cnt - 8'h01;
            end
        end else if (!i_sleep) begin
            ram_en_q <= 1'b1; // software enables ram again once running
        end
        // mode pins only move while fully running
        if (sleep_n_q && init_n_q) boot_q <= i_boot;
    end
endmodule

/* hardware_standby_control_tb.sv */
`timescale 1ns/1ps
module hardware_standby_control_tb;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       sleep_cmd = 1'b0;
    logic [7:0] settle = 8'h00;
    logic [1:0] boot = 2'h3;
    logic [1:0] b;
    logic       sleep_n, init_n;
    logic [1:0] bsel;
    logic [8:0] seen;
    logic       clk_en = 1'b1;
    logic       ram_en;
    int         miscompares = 0;
    int         cmp_count = 0;
    int         seed = 73768;

    // =========================================================
    // clock, partner and device
    initial forever #5 clk = ~clk;

    hw_supervisor_model u_hw_supervisor_model (.i_clk(clk),
        .i_sleep(sleep_cmd), .i_settle(settle), .i_boot(boot),
        .o_sleep_n(sleep_n), .o_init_n(init_n), .o_boot(bsel),
        .o_ram_enable(ram_en));

    hw_standby_ctrl #(.SEQ_CYCLES(4)) u_hw_standby_ctrl (.I_REF_CLK(clk),
        .I_SYS_RST(rst), .I_CLK_EN(clk_en), .I_HW_SLEEP_REQUEST_N(sleep_n),
        .I_CHIP_INIT_N(init_n), .I_BOOT_SELECT_1(bsel[1]),
        .I_BOOT_SELECT_0(bsel[0]), .O_CPU_HALT(seen[8]),
        .O_MODULE_STOP(seen[7]), .O_MODULE_RESET(seen[6]),
        .O_PORT_HIZ(seen[5]), .O_RAM_RETAIN(seen[4]),
        .O_OSC_ENABLE(seen[3]), .O_CPU_RESET(seen[2]),
        .O_PROGRAMMER_MODE(seen[1]), .O_IN_STANDBY(seen[0]));

    // =========================================================
    // helpers: settle after an edge, compare, expected outputs
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic cmp(input string what, input logic [8:0] e);
        cmp_count++;
        if (seen !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, e, seen);
        end
    endtask

    task automatic cmp_bit(input string what, input logic e, input logic s);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask

    function automatic logic [8:0] expect_v(logic sb, logic rs, logic pg);
        return {sb, sb, rs, sb, sb, ~sb, rs, pg & sb, sb};
    endfunction

    task automatic print_verdict;
        if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // =========================================================
    // watchdog, far beyond a dozen standby round trips
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end

    // =========================================================
    // main sequence; odd rounds re-enter without waiting for the running check
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        step(1);
        cmp("after_reset", expect_v(1'b0, 1'b0, 1'b0));
        for (int i = 0; i < 12; i++) begin
            b = (i == 3) ? 2'h0 : 2'(1 + $unsigned($random(seed)) % 3);
            boot   <= b;
            settle <= 8'($unsigned($random(seed)) % 20);
            step(2 + $unsigned($random(seed)) % 5);
            sleep_cmd <= 1'b1;
            for (int k = 0; k < 20 && sleep_n !== 1'b0; k++) step(1);
            step(3);
            cmp("entry", expect_v(1'b1, 1'b1, b == 2'h0));
            cmp_bit("ram_enable", 1'b0, ram_en);
            // mid-run reset while the pin stays low: standby comes back
            if (i == 7) begin
                @(posedge clk);
                rst <= 1'b1;
                step(2);
                cmp("mid_reset", expect_v(1'b0, 1'b0, 1'b0));
                @(posedge clk);
                rst <= 1'b0;
                step(3);
                cmp("reenter", expect_v(1'b1, 1'b1, b == 2'h0));
            end
            step(1 + $unsigned($random(seed)) % 6);
            sleep_cmd <= 1'b0;
            for (int k = 0; k < 20 && sleep_n !== 1'b1; k++) step(1);
            step(3);
            cmp("osc_restart", expect_v(1'b0, 1'b1, 1'b0));
            for (int k = 0; k < 40 && init_n !== 1'b1; k++) step(1);
            step(3);
            cmp("reset_seq", expect_v(1'b0, 1'b1, 1'b0));
            if (i % 2 == 0) begin
                // a low enable must stretch the reset sequence
                if (i == 2) begin
                    @(posedge clk);
                    clk_en <= 1'b0;
                    step(8);
                    cmp("frozen", expect_v(1'b0, 1'b1, 1'b0));
                    @(posedge clk);
                    clk_en <= 1'b1;
                end
                for (int k = 0; k < 12 && seen[2] !== 1'b0; k++) step(1);
                cmp("running", expect_v(1'b0, 1'b0, 1'b0));
            end
        end
        print_verdict();
    end
endmodule
